//--- hdl/gpsc_defines.svh
// Purpose: constants of the pin and aux serial control block
// Assumes: included by bare name
// Notes:   offsets, fields, reset value and timing counts
`ifndef GPSC_DEFINES_SVH
`define GPSC_DEFINES_SVH

// register index, byte address is four times it
`define GPSC_CTL_IDX    30'h0000_0006
`define GPSC_CTL_W      24
`define GPSC_CTL_RESET  24'h000000
`define GPSC_CTL_WMASK  24'h05eeee

// per-pin field layout, pin i starts at bit 4*i
`define GPSC_PIN_STRIDE 4
`define GPSC_IN_OFS     0
`define GPSC_OUT_OFS    1
`define GPSC_MODE_OFS   2
`define GPSC_EN_BIT     16
`define GPSC_FW_BIT     18

// pin mode codes
`define GPSC_M_HIZ      2'h0
`define GPSC_M_IN       2'h1
`define GPSC_M_PUSH     2'h2
`define GPSC_M_OD       2'h3

// sample pacing
`define GPSC_CLK_HZ     250000000
`define GPSC_RATE_HZ    128000
`define GPSC_TICK_CYC   (`GPSC_CLK_HZ / `GPSC_RATE_HZ)

`endif

//--- hdl/gpsc_pkg.sv
// Purpose: types of the pin and aux serial control block
// Assumes: nothing
// Notes:   constants live in gpsc_defines.svh
package gpsc_pkg;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b001,
    L_SHIFT = 3'b010,
    L_GAP   = 3'b100
  } gpsc_lstate_t;

endpackage : gpsc_pkg

//--- hdl/gpsc_top.sv
// Purpose: four-pin control register with aux serial sample port
// Assumes: AHB-Lite single word transfers; link_clk runs freely
// Notes:   ce freezes the hclk domain only
//
// Functional notes
// - mode 00 hi-z, 01 input, 10 push-pull output, 11 open drain.
// - pin 0: mode bits 3:2, out level bit 1, in level bit 0.
// - pin 1: mode bits 7:6, out level bit 5, in level bit 4.
// - pin 2: mode bits 11:10, out level bit 9, in level bit 8.
// - pin 3: mode bits 15:14, out level bit 13, in level bit 12.
// - output or open-drain pins follow their out level bit.
// - in level bits are read-only, show pin level in input mode.
// - bit 16 starts aux serial port on pins 0-2, 128 kHz words.
// - while serial enabled pins 0-2 ignore their fields; pin 3 not.
// - bit 18: 0 select spans frame, 1 select per word.
// - register resets to zero: hi-z pins, serial off, frame select.
`include "gpsc_defines.svh"

module gpsc_top #(
  parameter int SAMPLE_W    = 24,
  parameter int FRAME_WORDS = 8,
  parameter int TICK_CYC    = `GPSC_TICK_CYC
) (
  // system
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // ecg sample source
  input  wire logic [SAMPLE_W-1:0] sample_data,
  output logic                     sample_taken,
  // link
  input  wire logic                link_clk,
  // pins
  input  wire logic [3:0]          pin_in,
  output logic      [3:0]          pin_out,
  output logic      [3:0]          pin_oe_n
);

  localparam int CW  = `GPSC_CTL_W;
  localparam int TW  = $clog2(TICK_CYC + 1);
  localparam int BW  = $clog2(SAMPLE_W + 1);
  localparam int FWW = $clog2(FRAME_WORDS + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
  localparam logic [BW-1:0] BIT_LAST  = BW'(SAMPLE_W - 1);
  localparam logic [FWW-1:0] WORD_LAST = FWW'(FRAME_WORDS - 1);

  // {out, oe_n} of a pin from its mode and level
  function automatic logic [1:0] pin_drive(input logic [1:0] m,
                                           input logic       lv);
    logic [1:0] r;
    r = 2'h1;
    case (m)
      `GPSC_M_PUSH: r = {lv, 1'b0};
      `GPSC_M_OD:   r = {1'b0, lv};
      default:      r = 2'h1;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // hclk domain state
  logic [CW-1:0]       ctl_q, ctl_d, ctl_w;
  logic                wr_q, wr_d;
  logic [31:0]         hrdata_q, hrdata_d;
  logic                hreadyout_q, hresp_q;
  logic [3:0]          pin_s1_q, pin_s2_q;
  logic [TW-1:0]       tick_q, tick_d;
  logic [SAMPLE_W-1:0] hold_q, hold_d;
  logic                req_q, req_d;
  logic                ack_s1_q, ack_s2_q;
  logic                taken_q, taken_d;
  logic                p3_out_q, p3_out_d;
  logic                p3_oen_q, p3_oen_d;
  logic [3:0]          rd_in;
  logic                take, hit, tick, busy;

  // link domain state
  gpsc_pkg::gpsc_lstate_t st_q, st_d;
  logic [14:0]         cfg_s1_q, cfg_s2_q;
  logic                req_s1_q, req_s2_q;
  logic                ack_l_q, ack_l_d;
  logic [SAMPLE_W-1:0] sh_q, sh_d;
  logic [BW-1:0]       bit_q, bit_d;
  logic [FWW-1:0]      wrd_q, wrd_d;
  logic                sclk_q, sclk_d;
  logic                sel_n_q, sel_n_d;
  logic [2:0]          lp_out_q, lp_out_d;
  logic [2:0]          lp_oen_q, lp_oen_d;
  logic                l_en, l_fw, pend;

  ////////////////////////////////////////////////////////////////////
  // input level read-back, only meaningful in input mode
  for (genvar i = 0; i < 4; i++) begin : g_in
    localparam int B = i * `GPSC_PIN_STRIDE;
    assign rd_in[i] =
      (ctl_w[B+`GPSC_MODE_OFS +: 2] == `GPSC_M_IN) ?
      pin_s2_q[i] : 1'b0;
  end

  assign take = hsel && htrans[1] && hready;
  assign hit  = (haddr[31:2] == `GPSC_CTL_IDX);
  assign tick = (tick_q == TICK_LAST);
  assign busy = (req_q != ack_s2_q);
  assign ctl_w = wr_q ? (hwdata[CW-1:0] & `GPSC_CTL_WMASK)
                      : ctl_q;

  always_comb begin
    logic [CW-1:0] rv;
    rv       = '0;
    ctl_d    = ctl_w;
    wr_d     = take && hwrite && hit;
    hrdata_d = hrdata_q;
    tick_d   = tick ? '0 : tick_q + 1'b1;
    hold_d   = hold_q;
    req_d    = req_q;
    taken_d  = 1'b0;
    // read data follows a write in the cycle before
    for (int i = 0; i < 4; i++) begin
      rv[i*`GPSC_PIN_STRIDE + `GPSC_IN_OFS] = rd_in[i];
    end
    rv = rv | ctl_d;
    if (take) begin
      hrdata_d = (!hwrite && hit) ? {{(32-CW){1'b0}}, rv} : 32'h0;
    end
    // a word is dropped if the link still shifts the last one
    if (tick && ctl_q[`GPSC_EN_BIT] && !busy) begin
      hold_d  = sample_data;
      req_d   = ~req_q;
      taken_d = 1'b1;
    end
    {p3_out_d, p3_oen_d} =
      pin_drive(ctl_q[15:14], ctl_q[13]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q       <= `GPSC_CTL_RESET;
      wr_q        <= 1'b0;
      hrdata_q    <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      pin_s1_q    <= 4'h0;
      pin_s2_q    <= 4'h0;
      tick_q      <= '0;
      hold_q      <= '0;
      req_q       <= 1'b0;
      ack_s1_q    <= 1'b0;
      ack_s2_q    <= 1'b0;
      taken_q     <= 1'b0;
      p3_out_q    <= 1'b0;
      p3_oen_q    <= 1'b1;
    end else if (ce) begin
      ctl_q       <= ctl_d;
      wr_q        <= wr_d;
      hrdata_q    <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      pin_s1_q    <= pin_in;
      pin_s2_q    <= pin_s1_q;
      tick_q      <= tick_d;
      hold_q      <= hold_d;
      req_q       <= req_d;
      ack_s1_q    <= ack_l_q;
      ack_s2_q    <= ack_s1_q;
      taken_q     <= taken_d;
      p3_out_q    <= p3_out_d;
      p3_oen_q    <= p3_oen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link domain: serial shifter and pins 0..2
  // pin 0 serial clock, pin 1 data msb first, pin 2 select
  assign l_en = cfg_s2_q[12];
  assign l_fw = cfg_s2_q[14];
  assign pend = (req_s2_q != ack_l_q);

  always_comb begin
    st_d    = st_q;
    ack_l_d = ack_l_q;
    sh_d    = sh_q;
    bit_d   = bit_q;
    wrd_d   = wrd_q;
    sclk_d  = 1'b0;
    sel_n_d = sel_n_q;
    if (!l_en) begin
      st_d    = gpsc_pkg::L_IDLE;
      sel_n_d = 1'b1;
      wrd_d   = '0;
      ack_l_d = req_s2_q;
    end else begin
      case (st_q)
        gpsc_pkg::L_IDLE: begin
          if (pend) begin
            sh_d    = hold_q;
            bit_d   = '0;
            sel_n_d = 1'b0;
            st_d    = gpsc_pkg::L_SHIFT;
          end
        end
        gpsc_pkg::L_SHIFT: begin
          sclk_d = ~sclk_q;
          if (sclk_q) begin
            if (bit_q == BIT_LAST) begin
              ack_l_d = ~ack_l_q;
              wrd_d   = (wrd_q == WORD_LAST) ? '0 : wrd_q + 1'b1;
              if (l_fw || wrd_q == WORD_LAST) begin
                sel_n_d = 1'b1;
                st_d    = gpsc_pkg::L_GAP;
              end else begin
                st_d    = gpsc_pkg::L_IDLE;
              end
            end else begin
              sh_d  = {sh_q[SAMPLE_W-2:0], 1'b0};
              bit_d = bit_q + 1'b1;
            end
          end
        end
        gpsc_pkg::L_GAP: st_d = gpsc_pkg::L_IDLE;
        default: begin
          st_d    = gpsc_pkg::L_IDLE;
          sel_n_d = 1'b1;
        end
      endcase
    end
    // serial port owns pins 0..2 and overrides their fields
    if (l_en) begin
      lp_out_d = {sel_n_d, sh_d[SAMPLE_W-1], sclk_d};
      lp_oen_d = 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        {lp_out_d[i], lp_oen_d[i]} = pin_drive(
          cfg_s2_q[i*4+2 +: 2], cfg_s2_q[i*4+1]);
      end
    end
  end

  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= gpsc_pkg::L_IDLE;
      cfg_s1_q <= 15'h0;
      cfg_s2_q <= 15'h0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_l_q  <= 1'b0;
      sh_q     <= '0;
      bit_q    <= '0;
      wrd_q    <= '0;
      sclk_q   <= 1'b0;
      sel_n_q  <= 1'b1;
      lp_out_q <= 3'h0;
      lp_oen_q <= 3'h7;
    end else begin
      st_q     <= st_d;
      cfg_s1_q <= {ctl_q[18:16], ctl_q[11:0]};
      cfg_s2_q <= cfg_s1_q;
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      ack_l_q  <= ack_l_d;
      sh_q     <= sh_d;
      bit_q    <= bit_d;
      wrd_q    <= wrd_d;
      sclk_q   <= sclk_d;
      sel_n_q  <= sel_n_d;
      lp_out_q <= lp_out_d;
      lp_oen_q <= lp_oen_d;
    end
  end

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = hresp_q;
  assign sample_taken = taken_q;
  assign pin_out      = {p3_out_q, lp_out_q};
  assign pin_oe_n     = {p3_oen_q, lp_oen_q};

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_reset_zero: assert property (
    !$past(hresetn) |-> ctl_q == '0 && p3_oen_q)
    else $error("control not zero after reset");

  chk_write_fields: assert property (
    ce && wr_q |=> ctl_q == ($past(hwdata[CW-1:0]) & `GPSC_CTL_WMASK))
    else $error("written fields not stored");

  chk_in_level: assert property (
    ce && take && !hwrite && hit && !wr_q && ctl_q[15:14] == 2'h1
    |=> hrdata_q[12] == $past(pin_s2_q[3]))
    else $error("pin 3 input level not read back");

  chk_in_masked: assert property (
    ce && take && !hwrite && hit && !wr_q && ctl_q[15:14] != 2'h1
    |=> !hrdata_q[12])
    else $error("pin 3 input level shown outside input mode");

  chk_pin3_push: assert property (
    ce && ctl_q[15:14] == 2'h2 |=> !p3_oen_q && p3_out_q == $past(ctl_q[13]))
    else $error("pin 3 push-pull drive wrong");

  chk_pin3_od: assert property (
    ce && ctl_q[15:14] == 2'h3 |=> p3_oen_q == $past(ctl_q[13]) && !p3_out_q)
    else $error("pin 3 open drain drive wrong");

  chk_pin3_hiz: assert property (
    ce && !ctl_q[15] |=> p3_oen_q)
    else $error("pin 3 driven in hi-z or input mode");

  chk_sample_start: assert property (
    ce && tick && ctl_q[`GPSC_EN_BIT] && !busy |=> busy && taken_q)
    else $error("sample not handed to link");

  chk_serial_pins: assert property (
    @(posedge link_clk) disable iff (!hresetn)
    l_en && $past(l_en) |-> lp_oen_q == 3'h0)
    else $error("serial pins not driven while enabled");

  chk_word_select: assert property (
    @(posedge link_clk) disable iff (!hresetn)
    l_en && st_q == gpsc_pkg::L_GAP |-> lp_out_q[2] ##1 lp_out_q[2])
    else $error("select not released after word");

endmodule // gpsc_top

//--- verif/gpsc_link_rx.sv
// Purpose: far-end receiver model of the aux serial link
// Assumes: pin0 clock, pin1 data msb first, pin2 select low active
// Notes:   takes data on the rising clock, counts select releases
module gpsc_link_rx #(
  parameter int W = 24
) (
  // link pins
  input  wire logic     sclk,
  input  wire logic     sdata,
  input  wire logic     sel_n,
  input  wire logic     rst_n,
  // decoded stream
  output logic [W-1:0]  word,
  output int            words,
  output int            rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] sh;
  int           bits, r_seen;
  //////////////////////////////////////////////////////////////////////////
  always @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      bits   = 0;
      words  = 0;
      r_seen = 0;
    end else if (!sel_n) begin
      // a select release abandons any part word
      if (rises != r_seen) bits = 0;
      r_seen = rises;
      sh = {sh[W-2:0], sdata};
      bits++;
      if (bits == W) begin
        word = sh;
        words++;
        bits = 0;
      end
    end
  end
  // a release marks a word or a frame boundary
  always @(posedge sel_n or negedge rst_n) begin
    if (!rst_n) rises = 0;
    else rises++;
  end
endmodule // gpsc_link_rx

//--- verif/testbench.sv
// Purpose: self-checking bench of the pin and aux serial control block
// Assumes: register at byte 0x18, one-cycle bus answer
// Notes:   long sample tick shortened to 1000 cycles
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %0t mismatch", $time); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0;
  logic        hreadyout, hresp, taken, link_clk = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = '0;
  logic [23:0] sdat = '0, v, word;
  logic [3:0]  ext = '0, pin_out, pin_oe_n, pin_w;
  int          fail_count = 0, checks_done = 0, seed = 64254, cyc = 0;
  int          words, rises, w0, r0, n0, ntaken = 0;
  // released pins show what the outside world drives
  assign pin_w = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
  always #2 hclk = ~hclk;
  initial begin
    #5;
    forever #32 link_clk = ~link_clk;
  end
  gpsc_top #(.SAMPLE_W(24), .FRAME_WORDS(2), .TICK_CYC(1000)) uut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_data(sdat), .sample_taken(taken),
    .link_clk(link_clk), .pin_in(pin_w), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  gpsc_link_rx #(.W(24)) rx (.sclk(pin_w[0]), .sdata(pin_w[1]),
    .sel_n(pin_w[2]), .rst_n(hresetn), .word(word), .words(words),
    .rises(rises));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] exp_pin(logic [1:0] m, logic l);
    case (m)
      2'h2: return {1'b0, l};
      2'h3: return {l, 1'b0};
      default: return 2'b10;
    endcase
  endfunction
  function automatic logic [23:0] exp_rd(logic [23:0] w, logic [3:0] e);
    logic [23:0] r;
    r = w & 24'h05eeee;  // in levels and reserved bits hold nothing
    for (int i = 0; i < 4; i++) if (w[4*i+3 -: 2] == 2'h1) r[4*i] = e[i];
    return r;
  endfunction
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic pin_case(input logic [23:0] x);
    ext <= 4'($random(seed));
    bus(1'b1, 32'h18, {8'h0, x});
    repeat (60) @(posedge hclk);
    bus(1'b0, 32'h18, 32'h0);
    `CHK(rd, {8'h0, exp_rd(x, ext)})
    for (int i = 0; i < 4; i++)
      `CHK({pin_oe_n[i], pin_out[i]}, exp_pin(x[4*i+3 -: 2], x[4*i+1]))
  endtask
  task automatic ser(input logic fw);
    sdat <= 24'($random(seed));
    n0 = ntaken;
    bus(1'b1, 32'h18, {8'h0, 5'h0, fw, 2'h1, 16'he0a0});
    // the link takes the pins over a few link cycles later
    repeat (100) @(posedge hclk);
    w0 = words;
    r0 = rises;
    for (int t = 0; t < 6000 && words < w0 + 4; t++) @(posedge hclk);
    repeat (64) @(posedge hclk);
    `CHK(word, sdat)
    `CHK(words - w0, 4)
    `CHK((ntaken - n0) inside {[4:5]}, 1'b1)
    `CHK(rises - r0, fw ? 4 : 2)
    `CHK({pin_oe_n, pin_out[3]}, 5'b10000)
    bus(1'b1, 32'h18, 32'h0);
    $display("test serial framing %0d done", fw);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // hang guard, well above the roughly 10k cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (taken === 1'b1) ntaken <= ntaken + 1;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    // link domain also needs two edges inside reset
    repeat (2) @(posedge link_clk);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h18, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(pin_oe_n, 4'hf)
    bus(1'b0, 32'h1c, 32'h0);
    `CHK(rd, 32'h0)
    // a write made while the clock enable is low is lost
    ce <= 1'b0;
    bus(1'b1, 32'h18, 32'h0000c000);
    ce <= 1'b1;
    bus(1'b0, 32'h18, 32'h0);
    `CHK(rd, 32'h0)
    `CHK({hresp, hreadyout, pin_oe_n[3]}, 3'b011)
    $display("test reset done");
    // every mode with both levels, in-level bits written as ones
    for (int k = 0; k < 8; k++)
      pin_case({5'h0, k[0], 2'h0, {4{k[2:1], k[0], 1'b1}}});
    repeat (8) begin
      v = 24'($random(seed));
      v[16] = 1'b0;
      pin_case(v);
    end
    $display("test pins done");
    ser(1'b1);
    ser(1'b0);
    summarize();
  end
endmodule // testbench
